// >>> hdl/tape_host_port.sv
/*
 * Board end of the eight-bit parallel tape cable: command, status and data
 * byte handshakes, reset pulse, online control and exception follow-up.
 * Assumes cable inputs are synchronous to clock_i; pad logic joins the
 * three bus signals into the two-way wire.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// (RULE1) One eight-bit two-way bus, bit 7 most significant, carries everything.
// (RULE2) Abort a read or write by dropping tape online.
// (RULE3) Request line marks a command byte and paces status bytes.
// (RULE4) Pulse tape reset after power-up.
// (RULE5) Transfer strobe marks byte taken on read, byte placed on write.
// (RULE6) Tape acknowledge marks read byte valid or write byte accepted.
// (RULE7) Commands go out only while tape ready is true.
// (RULE8) Tape ready during a command byte shows it was read.
// (RULE9) Tape ready also paces data blocks and status bytes; the code paces status bytes on ready, data bytes on acknowledge.
// (RULE10) Tape raises exception when an operation has been terminated.
// (RULE11) On exception the board issues a status-fetch command.
// (RULE12) Direction true means the tape drives the bus.
// (RULE13) Board drives the bus only while direction is false.
// (RULE14) All cable signals, bus bits included, are active low.
// (RULE15) Each byte handshake completes before the next starts.
module tape_host_port #(
	parameter int RESET_CYCLES = tape_port_pkg::RESET_PULSE_CYCLES
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic online_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [1:0] req_kind_i,
	input wire logic [7:0] req_data_i,
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output logic [7:0] rsp_data_o,
	output logic exception_o,
	output logic fetch_busy_o,
	input wire logic [7:0] tape_bus_bits_n_i,
	output logic [7:0] tape_bus_bits_n_o,
	output logic tape_bus_bits_oe_o,
	output logic tape_online_n_o,
	output logic tape_request_n_o,
	output logic tape_reset_line_n_o,
	output logic host_data_strobe_n_o,
	input wire logic tape_ack_n_i,
	input wire logic tape_ready_n_i,
	input wire logic tape_exception_n_i,
	input wire logic tape_direction_n_i
);
	tape_port_pkg::hs_state_t state, next_state;
	logic [15:0] count, next_count;
	logic [1:0] kind, next_kind;
	logic [7:0] out_byte, next_out_byte;
	logic req_line, next_req_line;
	logic strobe_line, next_strobe_line;
	logic reset_line, next_reset_line;
	logic fetch_pend, next_fetch_pend;
	logic fault_seen, next_fault_seen;
	logic buf_valid, buf_ready;
	logic [7:0] buf_data;
	logic ack, rdy, fault, tape_drives, resp;
	logic from_tape;

	// =========================================================================
	// Cable polarity: every line asserted is low. [RULE14]
	assign ack = !tape_ack_n_i;
	assign rdy = !tape_ready_n_i;
	assign fault = !tape_exception_n_i;
	assign tape_drives = !tape_direction_n_i; // [RULE12]
	assign from_tape = (kind == tape_port_pkg::KIND_STATUS) ||
		(kind == tape_port_pkg::KIND_READ);
	// Commands and status complete on ready; data bytes on acknowledge.
	assign resp = (kind[1] ? ack : rdy); // [RULE6] [RULE8] [RULE9]

	// =========================================================================
	// Handshake sequencer with reset pulse and exception follow-up.
	always_comb begin
		next_state = state;
		next_count = count;
		next_kind = kind;
		next_out_byte = out_byte;
		next_req_line = req_line;
		next_strobe_line = strobe_line;
		next_reset_line = reset_line;
		next_fetch_pend = fetch_pend || (fault && !fault_seen); // [RULE11]
		next_fault_seen = fault;
		buf_valid = 1'b0;
		case (state)
			tape_port_pkg::ST_POWERUP: begin
				next_reset_line = 1'b1; // [RULE4]
				if (count == 16'(RESET_CYCLES - 1)) begin
					next_reset_line = 1'b0;
					next_state = tape_port_pkg::ST_IDLE;
				end
				next_count = count + 16'h1;
			end
			tape_port_pkg::ST_IDLE: begin
				next_count = 16'h0;
				if (fetch_pend && rdy && !tape_drives) begin
					// Status fetch outranks user work. [RULE7] [RULE11]
					next_kind = tape_port_pkg::KIND_COMMAND;
					next_out_byte = tape_port_pkg::STATUS_FETCH_CMD;
					// A fresh exception in this same cycle must survive the clear.
					next_fetch_pend = fault && !fault_seen; // [RULE11]
					next_state = tape_port_pkg::ST_SETTLE;
				end else if (req_valid_i && req_ready_o) begin
					next_kind = req_kind_i;
					next_out_byte = req_data_i;
					next_state = tape_port_pkg::ST_SETTLE;
				end
			end
			tape_port_pkg::ST_SETTLE: begin
				// Data settles on the bus before the strobe falls.
				next_count = count + 16'h1;
				if (count >= 16'(tape_port_pkg::SETTLE_CYCLES - 1)) begin
					if (kind[1]) begin
						next_strobe_line = kind == tape_port_pkg::KIND_WRITE; // [RULE5]
					end else begin
						next_req_line = 1'b1; // [RULE3]
					end
					next_state = tape_port_pkg::ST_WAIT_ACK;
				end
			end
			tape_port_pkg::ST_WAIT_ACK: begin
				if (resp && (!from_tape || buf_ready)) begin
					buf_valid = from_tape;
					if (kind == tape_port_pkg::KIND_READ) begin
						next_strobe_line = 1'b1; // [RULE5]
					end else if (kind != tape_port_pkg::KIND_WRITE) begin
						next_req_line = !from_tape; // [RULE3]
					end
					next_state = tape_port_pkg::ST_WAIT_DROP;
				end
			end
			tape_port_pkg::ST_WAIT_DROP: begin
				// Strobes release only after the response; next byte waits. [RULE15]
				next_strobe_line = 1'b0;
				next_req_line = 1'b0;
				if (!resp) begin
					next_state = tape_port_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = tape_port_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers only; every next value is worked out in the sequencer.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= tape_port_pkg::ST_POWERUP;
			count <= 16'h0;
			kind <= tape_port_pkg::KIND_COMMAND;
			out_byte <= 8'h00;
			req_line <= 1'b0;
			strobe_line <= 1'b0;
			reset_line <= 1'b1;
			fetch_pend <= 1'b0;
			fault_seen <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			kind <= next_kind;
			out_byte <= next_out_byte;
			req_line <= next_req_line;
			strobe_line <= next_strobe_line;
			reset_line <= next_reset_line;
			fetch_pend <= next_fetch_pend;
			fault_seen <= next_fault_seen;
		end
	end

	// =========================================================================
	// Bytes from the tape pass a two-entry buffer so a stalled user loses none.
	assign buf_data = ~tape_bus_bits_n_i; // [RULE1] [RULE14]
	tape_skid_buffer #(
		.WIDTH(tape_port_pkg::BUS_WIDTH)
	) rx_buffer (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(buf_valid),
		.in_ready_o(buf_ready),
		.in_data_i(buf_data),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i),
		.out_data_o(rsp_data_o)
	);

	// =========================================================================
	// Cable outputs; drivers stay off whenever the tape owns the bus.
	assign tape_bus_bits_n_o = ~out_byte; // [RULE1]
	assign tape_bus_bits_oe_o = !tape_drives && !from_tape &&
		(state != tape_port_pkg::ST_IDLE) &&
		(state != tape_port_pkg::ST_POWERUP); // [RULE13]
	assign tape_online_n_o = !online_i; // [RULE2]
	assign tape_request_n_o = !req_line;
	assign tape_reset_line_n_o = !reset_line;
	assign host_data_strobe_n_o = !strobe_line;
	assign exception_o = fault; // [RULE10]
	assign fetch_busy_o = fetch_pend;
	// Commands wait for tape ready; a pending status fetch goes first.
	assign req_ready_o = (state == tape_port_pkg::ST_IDLE) && !fetch_pend &&
		(req_kind_i != tape_port_pkg::KIND_COMMAND || rdy); // [RULE7]

	// =========================================================================
	// Checks.
	sequence s_strobe_up;
		strobe_line && !$past(strobe_line);
	endsequence
	a_reset_pulse_first: assert property (@(posedge clock_i) // [RULE4]
		disable iff (!arst_n_i) state == tape_port_pkg::ST_POWERUP |-> reset_line)
		else $error("reset line not held during power-up");
	a_bus_release_dir: assert property (@(posedge clock_i) // [RULE13]
		disable iff (!arst_n_i) tape_drives |-> !tape_bus_bits_oe_o)
		else $error("board drives bus against direction");
	a_strobe_waits_resp: assert property (@(posedge clock_i) // [RULE5]
		disable iff (!arst_n_i) s_strobe_up and kind == tape_port_pkg::KIND_READ
		|-> $past(ack))
		else $error("read strobe without acknowledge");
	a_one_byte_handshake: assert property (@(posedge clock_i) // [RULE15]
		disable iff (!arst_n_i) $fell(req_line) || $fell(strobe_line)
		|-> state == tape_port_pkg::ST_WAIT_DROP ||
		state == tape_port_pkg::ST_IDLE)
		else $error("strobe released early");
	a_exception_fetch: assert property (@(posedge clock_i) // [RULE11]
		disable iff (!arst_n_i) $rose(fault) |=> fetch_pend)
		else $error("exception not followed by status fetch");
	a_command_needs_ready: assert property (@(posedge clock_i) // [RULE7]
		disable iff (!arst_n_i) req_valid_i && req_ready_o &&
		req_kind_i == tape_port_pkg::KIND_COMMAND |-> rdy)
		else $error("command taken while tape not ready");
	a_online_follows: assert property (@(posedge clock_i) // [RULE2]
		disable iff (!arst_n_i) tape_online_n_o == !online_i)
		else $error("online line wrong");
	a_request_command: assert property (@(posedge clock_i) // [RULE3]
		disable iff (!arst_n_i) $rose(req_line) |-> !kind[1])
		else $error("request raised for data byte");
endmodule // tape_host_port
`default_nettype wire

// >>> hdl/tape_port_pkg.sv
/*
 * Constants for the tape drive parallel host port: bus width, clock rate,
 * handshake kinds, reset pulse and settle timing and state codes.
 * Assumes a single 20 MHz clock; nothing else is needed from outside.
 */
package tape_port_pkg;
	// Bus width on the cable.
	localparam int BUS_WIDTH = 8;
	// Clock rate in kHz.
	localparam int CLOCK_KHZ = 20000;
	// Length of the tape reset pulse after power-up, in microseconds.
	localparam int RESET_PULSE_US = 100;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * CLOCK_KHZ) / 1000;
	// Settling time of the bus before a strobe, in nanoseconds.
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLOCK_KHZ + 999999) / 1000000;
	// Transfer kinds requested by the user side.
	localparam logic [1:0] KIND_COMMAND = 2'h0;
	localparam logic [1:0] KIND_STATUS = 2'h1;
	localparam logic [1:0] KIND_WRITE = 2'h2;
	localparam logic [1:0] KIND_READ = 2'h3;
	// Command byte that fetches status after an exception.
	localparam logic [7:0] STATUS_FETCH_CMD = 8'hc0;
	// Handshake state machine, Gray coded along the usual path.
	typedef enum logic [2:0] {
		ST_POWERUP = 3'h0,
		ST_IDLE = 3'h1,
		ST_SETTLE = 3'h3,
		ST_WAIT_ACK = 3'h7,
		ST_WAIT_DROP = 3'h5
	} hs_state_t;
endpackage

// >>> hdl/tape_skid_buffer.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the single system clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module tape_skid_buffer #(
	parameter int WIDTH = 8
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] slot [2];
	logic [1:0] count;
	logic rd_ptr;
	logic wr_ptr;
	logic [WIDTH-1:0] next_slot [2];
	logic [1:0] next_count;
	logic next_rd_ptr;
	logic next_wr_ptr;
	logic push;
	logic pop;

	// =========================================================================
	// Occupancy; a full buffer refuses, so a stalled reader loses nothing.
	always_comb begin
		push = in_valid_i && (count != 2'h2);
		pop = (count != 2'h0) && out_ready_i;
		next_slot = slot;
		if (push) begin
			next_slot[wr_ptr] = in_data_i;
		end
		next_wr_ptr = push ? !wr_ptr : wr_ptr;
		next_rd_ptr = pop ? !rd_ptr : rd_ptr;
		next_count = count + {1'b0, push} - {1'b0, pop};
	end

	// Registers only; slots and pointers follow the next values above.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			slot[0] <= '0;
			slot[1] <= '0;
			count <= 2'h0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end else begin
			slot <= next_slot;
			count <= next_count;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
		end
	end

	// Flags come from the count, so a full buffer never claims room.
	assign in_ready_o = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o = slot[rd_ptr];
endmodule // tape_skid_buffer
`default_nettype wire

// >>> test/tape_drive_model.sv
/* Behavioural tape drive for the host port bench.
   Assumes the bench clock and active-low cable levels. */
`timescale 1ns/100ps
`default_nettype none
module tape_drive_model (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic request_n_i,
	input wire logic strobe_n_i,
	input wire logic online_n_i,
	input wire logic [7:0] bus_n_i,
	input wire logic go_i,
	input wire logic [1:0] kind_i,
	input wire logic [7:0] byte_i,
	input wire logic [3:0] lag_i,
	output logic [7:0] bus_n_o,
	output logic ack_n_o,
	output logic ready_n_o,
	output logic dir_n_o,
	output logic [7:0] got_o
);
	logic [2:0] st;
	logic [3:0] cnt;
	// ==========
	// States: 0 ready, 1 command held, 2 busy, 3 status, 4 data.
	// A bus released at the end of a status or data byte shows the inverse of its last value.
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= 3'h0;
			cnt <= 4'h0;
			ready_n_o <= 1'b1;
			ack_n_o <= 1'b1;
			dir_n_o <= 1'b1;
			bus_n_o <= 8'h00;
			got_o <= 8'h00;
		end else if (online_n_i && st != 3'h0) begin
			st <= 3'h0;
			ack_n_o <= 1'b1;
			dir_n_o <= 1'b1;
		end else begin
			case (st)
				3'h0: begin
					ready_n_o <= 1'b0;
					if (!request_n_i && !ready_n_o) begin
						got_o <= ~bus_n_i;
						st <= 3'h1;
					end
				end
				3'h1: if (request_n_i) begin
					ready_n_o <= 1'b1;
					st <= 3'h2;
				end
				3'h2: begin
					if (!strobe_n_i && dir_n_o) begin
						if (cnt == lag_i) begin
							ack_n_o <= 1'b0;
							got_o <= ~bus_n_i;
						end else
							cnt <= cnt + 4'h1;
					end else if (strobe_n_i) begin
						ack_n_o <= 1'b1;
						cnt <= 4'h0;
					end
					if (go_i && kind_i == 2'h2)
						st <= 3'h0;
					else if (go_i) begin
						dir_n_o <= 1'b0;
						bus_n_o <= ~byte_i;
						st <= (kind_i == 2'h1) ? 3'h3 : 3'h4;
					end
				end
				3'h3: begin
					ready_n_o <= 1'b0;
					cnt <= cnt + 4'h1;
					if (cnt == 4'h2) begin
						ready_n_o <= 1'b1;
						dir_n_o <= 1'b1;
						bus_n_o <= ~bus_n_o;
						cnt <= 4'h0;
						st <= 3'h2;
					end
				end
				default: begin
					ack_n_o <= 1'b0;
					if (!strobe_n_i) begin
						ack_n_o <= 1'b1;
						dir_n_o <= 1'b1;
						bus_n_o <= ~bus_n_o;
						st <= 3'h2;
					end
				end
			endcase
		end
	end
endmodule // tape_drive_model
`default_nettype wire

// >>> test/tape_drive_parallel_host_port_bench.sv
/* Self-checking bench for the tape host port.
   Assumes the tape drive model and a 20 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module tape_drive_parallel_host_port_bench;
	localparam int RC = 8;
	logic clk = 0, arst_n = 0, online = 1, rv = 0, rr = 0, go = 0;
	logic fault_n = 1;
	logic [1:0] kind = 2'h0, gk = 2'h0;
	logic [7:0] rd = 8'h00, gb = 8'h00;
	logic [3:0] lag = 4'h0;
	logic rq_rdy, rs_v, fault, fb, oe, online_n, req_n, rl_n, stb_n;
	logic ack_n, rdy_n, dir_n;
	logic [7:0] rs_d, dout, mout, got;
	wire logic [7:0] bus;
	int errors = 0, num_checks = 0;
	// ==========
	// The wire level follows whichever side drives it.
	assign bus = oe ? dout : mout;
	always #25 clk = ~clk;
	tape_host_port #(.RESET_CYCLES(RC)) dut (.clock_i(clk),
		.arst_n_i(arst_n), .online_i(online), .req_valid_i(rv),
		.req_ready_o(rq_rdy), .req_kind_i(kind), .req_data_i(rd),
		.rsp_valid_o(rs_v), .rsp_ready_i(rr), .rsp_data_o(rs_d),
		.exception_o(fault), .fetch_busy_o(fb), .tape_bus_bits_n_i(bus),
		.tape_bus_bits_n_o(dout), .tape_bus_bits_oe_o(oe),
		.tape_online_n_o(online_n), .tape_request_n_o(req_n),
		.tape_reset_line_n_o(rl_n), .host_data_strobe_n_o(stb_n),
		.tape_ack_n_i(ack_n), .tape_ready_n_i(rdy_n),
		.tape_exception_n_i(fault_n), .tape_direction_n_i(dir_n));
	tape_drive_model drive (.clock_i(clk), .reset_n_i(rl_n),
		.request_n_i(req_n), .strobe_n_i(stb_n), .online_n_i(online_n),
		.bus_n_i(bus), .go_i(go), .kind_i(gk), .byte_i(gb), .lag_i(lag),
		.bus_n_o(mout), .ack_n_o(ack_n), .ready_n_o(rdy_n),
		.dir_n_o(dir_n), .got_o(got));
	// A clash on the cable is reported at once.
	always @(negedge clk) begin
		if (oe === 1'b1 && dir_n === 1'b0) begin
			errors++;
			$display("CHECK FAILED bus_oe expected 0 seen 1");
		end
	end
	// ==========
	// Shared tasks.
	task automatic chk(input string w, input logic [7:0] e, s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Polls the ready flag just after each rising edge, within a bound; a
	// hang counts a mismatch and the run goes on to the closing report.
	task automatic await(input logic [1:0] k);
		int i;
		kind = k;
		for (i = 0; i < 300 && rq_rdy !== 1'b1; i++)
			tick(1);
		if (i == 300) begin
			chk("handshake", 8'h01, 8'h00);
		end
	endtask
	task automatic send(input logic [1:0] k, input logic [7:0] d);
		rd = d;
		rv = 1'b1;
		await(k);
		tick(1);
		rv = 1'b0;
	endtask
	task automatic give(input logic [1:0] k, input logic [7:0] d);
		tick(3);
		gk = k;
		gb = d;
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask
	task automatic pop(input logic [7:0] e);
		chk("response byte", e, rs_d);
		rr = 1'b1;
		tick(1);
		rr = 1'b0;
	endtask
	// ==========
	// Scenarios.
	task automatic t_reset;
		int i;
		tick(4);
		arst_n = 1'b1;
		for (i = 0; i < 50 && rl_n !== 1'b1; i++)
			tick(1);
		chk("reset cycles", 8'(RC), 8'(i));
		$display("test reset done");
	endtask
	task automatic t_cmd;
		send(tape_port_pkg::KIND_COMMAND, 8'ha5);
		await(tape_port_pkg::KIND_WRITE);
		chk("command", 8'ha5, got);
		kind = tape_port_pkg::KIND_COMMAND;
		#1 chk("refused", 8'h00, 8'(rq_rdy));
		chk("request released", 8'h01, 8'(req_n));
		$display("test command done");
	endtask
	task automatic t_write;
		send(tape_port_pkg::KIND_WRITE, 8'h81);
		lag = 4'h5;
		// An edge passes so valid is never lowered and raised in one step.
		tick(1);
		send(tape_port_pkg::KIND_WRITE, 8'h3c);
		chk("first write", 8'h81, got);
		await(tape_port_pkg::KIND_WRITE);
		chk("second write", 8'h3c, got);
		chk("strobe", 8'h01, 8'(stb_n));
		$display("test write done");
	endtask
	task automatic t_read;
		send(tape_port_pkg::KIND_READ, 8'h00);
		give(2'h0, 8'h5a);
		send(tape_port_pkg::KIND_READ, 8'h00);
		give(2'h0, 8'hc3);
		send(tape_port_pkg::KIND_STATUS, 8'h00);
		give(2'h1, 8'h96);
		chk("buffer held", 8'h01, 8'(rs_v));
		pop(8'h5a);
		pop(8'hc3);
		await(tape_port_pkg::KIND_WRITE);
		tick(2);
		pop(8'h96);
		chk("buffer empty", 8'h00, 8'(rs_v));
		$display("test read done");
	endtask
	task automatic t_exc;
		int i;
		give(2'h2, 8'h00);
		fault_n = 1'b0;
		tick(1);
		chk("fetch pending", 8'h01, 8'(fb));
		chk("user held off", 8'h00, 8'(rq_rdy));
		for (i = 0; i < 200 && got !== tape_port_pkg::STATUS_FETCH_CMD; i++)
			tick(1);
		chk("fetch", tape_port_pkg::STATUS_FETCH_CMD, got);
		chk("exception", 8'h01, 8'(fault));
		fault_n = 1'b1;
		await(tape_port_pkg::KIND_WRITE);
		$display("test exception done");
	endtask
	task automatic t_abort;
		give(2'h2, 8'h00);
		send(tape_port_pkg::KIND_COMMAND, 8'h11);
		await(tape_port_pkg::KIND_WRITE);
		online = 1'b0;
		tick(1);
		chk("online line", 8'h01, 8'(online_n));
		tick(2);
		chk("rewound ready", 8'h00, 8'(rdy_n));
		online = 1'b1;
		$display("test abort done");
	endtask
	initial begin
		t_reset;
		t_cmd;
		t_write;
		t_read;
		t_exc;
		t_abort;
		print_verdict;
	end
endmodule // tape_drive_parallel_host_port_bench
`default_nettype wire
